// ==== logic/dacref_pkg.sv ====
// shared constants and types for the reference converter control block
package dacref_pkg;
   localparam int AV_ADDR_W = 4;
   localparam int AV_DATA_W = 32;
   localparam logic [AV_ADDR_W-1:0] CONV_CTRL_OFFS = 4'h0;
   localparam logic [AV_ADDR_W-1:0] LEVEL_CTRL_OFFS = 4'h4;
   localparam logic [AV_ADDR_W-1:0] STATUS_OFFS = 4'h8;
   localparam int CONV_EN_BIT = 7;
   localparam int LPS_BIT = 6;
   localparam int PIN_OE_BIT = 5;
   localparam int PSS_LSB = 2;
   localparam int NSS_BIT = 0;
   localparam logic [7:0] CONV_CTRL_MASK = 8'hed;
   localparam logic [7:0] LEVEL_CTRL_MASK = 8'h1f;
   localparam logic [7:0] CONV_CTRL_RST = 8'h00;
   localparam logic [7:0] LEVEL_CTRL_RST = 8'h00;
   localparam int LEVEL_W = 5;
   localparam int LEVEL_COUNT = 32;
   localparam logic [AV_DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      DACREF_PSRC_SUPPLY = 2'b00,
      DACREF_PSRC_EXTPIN = 2'b01,
      DACREF_PSRC_FIXREF = 2'b10,
      DACREF_PSRC_RSVD = 2'b11
   } dacref_psrc_t;

   typedef struct packed {
      logic [AV_ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [AV_DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } dacref_av_req_t;

   typedef struct packed {
      logic [AV_DATA_W-1:0] readdata;
      logic waitrequest;
   } dacref_av_rsp_t;

   typedef struct packed {
      logic converter_enable;
      logic low_power_state_select;
      logic pin_output_enable;
      dacref_psrc_t positive_source_select;
      logic negative_source_select;
      logic [LEVEL_W-1:0] level_select;
   } dacref_ctrl_t;
endpackage

// ==== logic/dacref_sync2.sv ====
// two-flop synchroniser for the digital pin input
`timescale 1ns/1ns
module dacref_sync2 (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   logic meta_d;
   logic dout_d;

   always_comb begin
      meta_d = din;
      dout_d = meta_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= meta_d;
         dout <= dout_d;
      end
   end
endmodule

// ==== logic/dacref_pin_mux.sv ====
// reference output pin override: analog connect, digital driver and input gating
`timescale 1ns/1ns
module dacref_pin_mux (
   input wire logic clk,
   input wire logic rst,
   input wire logic analog_sel,
   input wire logic port_out,
   input wire logic port_oe,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic port_in
);
   logic pad_in_s;
   logic port_in_d;

   dacref_sync2 u_sync (
      .clk(clk),
      .rst(rst),
      .din(pad_in),
      .dout(pad_in_s)
   );

   always_comb begin
      port_in_d = analog_sel ? 1'b0 : pad_in_s;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         port_in <= 1'b0;
      end else begin
         pad_out <= analog_sel ? 1'b0 : port_out;
         pad_oe <= analog_sel ? 1'b0 : port_oe;
         port_in <= port_in_d;
      end
   end

   pin_quiet_a: assert property (@(posedge clk) disable iff (rst)
      $past(analog_sel) |-> !pad_oe && !port_in)
      else $error("pin driven or read while routed to converter");
   read_zero_a: assert property (@(posedge clk) disable iff (rst)
      analog_sel && $past(analog_sel) |=> port_in == 1'b0)
      else $error("pin read nonzero in converter output mode");
endmodule

// ==== logic/dacref_top.sv ====
// reference converter control: registers on Avalon-MM and analog control outputs
// How it works
// - five-bit level field in low bits of level register picks one of 32 levels.
// - pin output enable set connects converter level to the output pin.
// - while pin carries the level, digital driver and input detection are off.
// - digital read of the pin in converter mode always returns zero.
// - converter enable bit turns the converter on, cleared turns it off.
// - low-power select picks positive source when one, negative when zero.
// - positive select 00 supply, 01 external pin, 10 fixed reference; 11 unused.
// - level register bits 7-5 read zero, level field in bits 4-0.
// - control register bits 4 and 1 ignore writes and read zero.
// - all implemented fields reset to zero on every reset.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module dacref_top
   import dacref_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [dacref_pkg::AV_ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [dacref_pkg::AV_DATA_W-1:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [dacref_pkg::AV_DATA_W-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic CONV_ENABLE,
   output logic [dacref_pkg::LEVEL_W-1:0] LEVEL_SELECT,
   output logic [dacref_pkg::LEVEL_COUNT-1:0] LEVEL_TAP,
   output logic POS_SRC_SUPPLY,
   output logic POS_SRC_EXTPIN,
   output logic POS_SRC_FIXREF,
   output logic NEG_SRC_EXTPIN,
   output logic NEG_SRC_GROUND,
   output logic LOW_POWER_POS,
   output logic PIN_ANALOG_CONNECT,
   input wire logic PORT_OUT,
   input wire logic PORT_OE,
   output logic PORT_IN,
   input wire logic PAD_I,
   output logic PAD_O,
   output logic PAD_OE
);
   import dacref_pkg::*;

   logic [7:0] conv_ctrl_q;
   logic [7:0] conv_ctrl_d;
   logic [7:0] level_ctrl_q;
   logic [7:0] level_ctrl_d;
   logic ack_q;
   logic ack_d;
   logic [AV_DATA_W-1:0] rdata_q;
   logic [AV_DATA_W-1:0] rdata_d;
   logic req;
   logic wr_fire;
   logic rd_fire;
   dacref_ctrl_t ctrl;
   logic [7:0] status_byte;

   // one wait cycle: write taken on the edge where waitrequest is low, read data captured on the edge before, while it is high
   assign req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_q;
   assign wr_fire = AVS_WRITE & ack_q;
   assign rd_fire = AVS_READ & ~ack_q;

   always_comb begin
      conv_ctrl_d = conv_ctrl_q;
      level_ctrl_d = level_ctrl_q;
      ack_d = req & ~ack_q;
      if (wr_fire && AVS_BYTEENABLE[0]) begin
         if (AVS_ADDRESS == CONV_CTRL_OFFS) begin
            conv_ctrl_d = AVS_WRITEDATA[7:0] & CONV_CTRL_MASK;
         end
         if (AVS_ADDRESS == LEVEL_CTRL_OFFS) begin
            level_ctrl_d = AVS_WRITEDATA[7:0] & LEVEL_CTRL_MASK;
         end
      end
   end

   always_comb begin
      ctrl.converter_enable = conv_ctrl_q[CONV_EN_BIT];
      ctrl.low_power_state_select = conv_ctrl_q[LPS_BIT];
      ctrl.pin_output_enable = conv_ctrl_q[PIN_OE_BIT];
      ctrl.positive_source_select = dacref_psrc_t'(conv_ctrl_q[PSS_LSB+1:PSS_LSB]);
      ctrl.negative_source_select = conv_ctrl_q[NSS_BIT];
      ctrl.level_select = level_ctrl_q[LEVEL_W-1:0];
      status_byte = {6'h00, ctrl.positive_source_select == DACREF_PSRC_RSVD, ctrl.pin_output_enable};
   end

   always_comb begin
      rdata_d = rdata_q;
      if (rd_fire) begin
         case (AVS_ADDRESS)
            CONV_CTRL_OFFS: rdata_d = {24'h000000, conv_ctrl_q & CONV_CTRL_MASK};
            LEVEL_CTRL_OFFS: rdata_d = {24'h000000, level_ctrl_q & LEVEL_CTRL_MASK};
            STATUS_OFFS: rdata_d = {24'h000000, status_byte};
            default: rdata_d = UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         conv_ctrl_q <= CONV_CTRL_RST;
         level_ctrl_q <= LEVEL_CTRL_RST;
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         conv_ctrl_q <= conv_ctrl_d;
         level_ctrl_q <= level_ctrl_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign AVS_READDATA = rdata_q;

   // analog control outputs decoded from the stored fields
   always_comb begin
      CONV_ENABLE = ctrl.converter_enable;
      LEVEL_SELECT = ctrl.level_select;
      LEVEL_TAP = '0;
      LEVEL_TAP[ctrl.level_select] = ctrl.converter_enable;
      LOW_POWER_POS = ctrl.low_power_state_select;
      // reserved code selects no source, so rails are never shorted
      POS_SRC_SUPPLY = ctrl.positive_source_select == DACREF_PSRC_SUPPLY;
      POS_SRC_EXTPIN = ctrl.positive_source_select == DACREF_PSRC_EXTPIN;
      POS_SRC_FIXREF = ctrl.positive_source_select == DACREF_PSRC_FIXREF;
      NEG_SRC_EXTPIN = ctrl.negative_source_select;
      NEG_SRC_GROUND = ~ctrl.negative_source_select;
      PIN_ANALOG_CONNECT = ctrl.pin_output_enable;
   end

   dacref_pin_mux u_pin (
      .clk(CLK),
      .rst(SYS_RST),
      .analog_sel(ctrl.pin_output_enable),
      .port_out(PORT_OUT),
      .port_oe(PORT_OE),
      .pad_in(PAD_I),
      .pad_out(PAD_O),
      .pad_oe(PAD_OE),
      .port_in(PORT_IN)
   );

   // bus handshake: exactly one wait cycle per request
   wait_first_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      req && !ack_q |-> AVS_WAITREQUEST)
      else $error("no wait cycle on new request");

   wait_second_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      req && ack_q |-> !AVS_WAITREQUEST)
      else $error("waitrequest held past one cycle");

   ack_pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ack_q |=> !ack_q)
      else $error("acknowledge longer than one cycle");

   ack_cause_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ack_q |-> $past(req))
      else $error("acknowledge without request");

   idle_no_wait_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !req |-> !AVS_WAITREQUEST)
      else $error("waitrequest high while idle");

   // register storage
   conv_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !(wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS) |=> $stable(conv_ctrl_q))
      else $error("control register changed without write");

   level_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !(wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == LEVEL_CTRL_OFFS) |=> $stable(level_ctrl_q))
      else $error("level register changed without write");

   conv_store_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS |=>
      conv_ctrl_q == ($past(AVS_WRITEDATA[7:0]) & CONV_CTRL_MASK))
      else $error("control register did not store write");

   conv_bits_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      conv_ctrl_q[4] == 1'b0 && conv_ctrl_q[1] == 1'b0)
      else $error("control unimplemented bits stored");

   level_bits_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      level_ctrl_q[7:5] == 3'h0)
      else $error("level unimplemented bits stored");

   // read path
   rdata_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !rd_fire |=> $stable(AVS_READDATA))
      else $error("read data changed without read");

   conv_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == CONV_CTRL_OFFS |=> AVS_READDATA == {24'h000000, $past(conv_ctrl_q)})
      else $error("control read differs from register");

   level_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == LEVEL_CTRL_OFFS |=> AVS_READDATA == {24'h000000, $past(level_ctrl_q)})
      else $error("level read differs from register");

   status_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == STATUS_OFFS |=>
      AVS_READDATA[31:2] == 30'h0 && AVS_READDATA[0] == $past(conv_ctrl_q[PIN_OE_BIT]))
      else $error("status read wrong");

   reserved_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == STATUS_OFFS |=>
      AVS_READDATA[1] == ($past(conv_ctrl_q[PSS_LSB+1:PSS_LSB]) == 2'h3))
      else $error("reserved code flag wrong");

   unmapped_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS != CONV_CTRL_OFFS && AVS_ADDRESS != LEVEL_CTRL_OFFS && AVS_ADDRESS != STATUS_OFFS
      |=> AVS_READDATA == UNMAPPED_DATA)
      else $error("unmapped read not zero");

   // analog control outputs, unimplemented-bit reads and reset values
   level_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      LEVEL_SELECT == level_ctrl_q[LEVEL_W-1:0])
      else $error("level select differs from register");

   level_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == LEVEL_CTRL_OFFS |=>
      LEVEL_SELECT == $past(AVS_WRITEDATA[LEVEL_W-1:0]))
      else $error("level select does not follow write");

   tap_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !CONV_ENABLE |-> LEVEL_TAP == 32'h0)
      else $error("level tap active while converter off");

   conv_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CONV_ENABLE == conv_ctrl_q[CONV_EN_BIT])
      else $error("converter enable differs from register");

   lps_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS |=>
      LOW_POWER_POS == $past(AVS_WRITEDATA[LPS_BIT]))
      else $error("low power select does not follow write");

   pos_supply_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      conv_ctrl_q[PSS_LSB+1:PSS_LSB] == 2'h0 |-> POS_SRC_SUPPLY && !POS_SRC_EXTPIN && !POS_SRC_FIXREF)
      else $error("code 00 does not pick supply");

   pos_extpin_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      conv_ctrl_q[PSS_LSB+1:PSS_LSB] == 2'h1 |-> !POS_SRC_SUPPLY && POS_SRC_EXTPIN && !POS_SRC_FIXREF)
      else $error("code 01 does not pick external pin");

   pos_fixref_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      conv_ctrl_q[PSS_LSB+1:PSS_LSB] == 2'h2 |-> !POS_SRC_SUPPLY && !POS_SRC_EXTPIN && POS_SRC_FIXREF)
      else $error("code 10 does not pick fixed reference");

   pos_reserved_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      conv_ctrl_q[PSS_LSB+1:PSS_LSB] == 2'h3 |-> !POS_SRC_SUPPLY && !POS_SRC_EXTPIN && !POS_SRC_FIXREF)
      else $error("reserved code drives a source");

   neg_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      NEG_SRC_EXTPIN == conv_ctrl_q[NSS_BIT])
      else $error("negative source differs from register");

   neg_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS |=>
      NEG_SRC_EXTPIN == $past(AVS_WRITEDATA[NSS_BIT]))
      else $error("negative source does not follow write");

   pin_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      PIN_ANALOG_CONNECT == conv_ctrl_q[PIN_OE_BIT])
      else $error("pin connect differs from register");

   level_onehot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CONV_ENABLE |-> $onehot(LEVEL_TAP) && LEVEL_TAP[LEVEL_SELECT])
      else $error("level tap does not match level code");

   pin_connect_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS |=>
      PIN_ANALOG_CONNECT == $past(AVS_WRITEDATA[PIN_OE_BIT]))
      else $error("pin connect does not follow written enable");

   conv_enable_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == CONV_CTRL_OFFS |=>
      CONV_ENABLE == $past(AVS_WRITEDATA[CONV_EN_BIT]))
      else $error("converter enable does not follow write");

   lps_follow_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      LOW_POWER_POS == conv_ctrl_q[LPS_BIT] && !(POS_SRC_SUPPLY && POS_SRC_FIXREF))
      else $error("low power select mismatch");

   pos_source_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      $countones({POS_SRC_SUPPLY, POS_SRC_EXTPIN, POS_SRC_FIXREF}) <= 1)
      else $error("more than one positive source selected");

   neg_source_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      NEG_SRC_EXTPIN != NEG_SRC_GROUND)
      else $error("negative source select inconsistent");

   level_unimpl_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == LEVEL_CTRL_OFFS |=> AVS_READDATA[7:5] == 3'h0)
      else $error("level register upper bits not zero");

   ctrl_unimpl_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      rd_fire && AVS_ADDRESS == CONV_CTRL_OFFS |=> AVS_READDATA[4] == 1'b0 && AVS_READDATA[1] == 1'b0)
      else $error("control register unimplemented bits not zero");

   reset_zero_a: assert property (@(posedge CLK) $fell(SYS_RST) |->
      conv_ctrl_q == 8'h00 && level_ctrl_q == 8'h00)
      else $error("register not zero after reset");

   // stored level is what a later read returns, checked by level_read_a
   readback_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      wr_fire && AVS_BYTEENABLE[0] && AVS_ADDRESS == LEVEL_CTRL_OFFS |=>
      level_ctrl_q == ($past(AVS_WRITEDATA[7:0]) & LEVEL_CTRL_MASK))
      else $error("level register did not store write");
endmodule

// ==== sim/tb_dacref_top.sv ====
// self-checking bench for the reference converter control block
`timescale 1ns/1ns
module tb_dacref_top;
   import dacref_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [AV_ADDR_W-1:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [AV_DATA_W-1:0] wdata = '0;
   logic [3:0] be = 4'h0;
   logic port_out = 1'b0;
   logic port_oe = 1'b0;
   logic pad_i = 1'b0;
   logic [AV_DATA_W-1:0] rdata;
   logic [AV_DATA_W-1:0] got;
   logic wait_rq, conv_en, ps_sup, ps_ext, ps_fix, ns_ext, ns_gnd, lp_pos, pin_conn, port_in, pad_o, pad_oe;
   logic [LEVEL_W-1:0] lvl_sel;
   logic [LEVEL_COUNT-1:0] lvl_tap;
   int error_cnt = 0;
   int samples_checked = 0;
   wire [7:0] outs = {conv_en, lp_pos, pin_conn, ps_sup, ps_ext, ps_fix, ns_ext, ns_gnd};
   wire [3:0] pins = {pad_o, pad_oe, port_in, pin_conn};

   always #2 clk = ~clk;

   dacref_top dut (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq),
      .CONV_ENABLE(conv_en), .LEVEL_SELECT(lvl_sel), .LEVEL_TAP(lvl_tap), .POS_SRC_SUPPLY(ps_sup),
      .POS_SRC_EXTPIN(ps_ext), .POS_SRC_FIXREF(ps_fix), .NEG_SRC_EXTPIN(ns_ext), .NEG_SRC_GROUND(ns_gnd),
      .LOW_POWER_POS(lp_pos), .PIN_ANALOG_CONNECT(pin_conn), .PORT_OUT(port_out), .PORT_OE(port_oe),
      .PORT_IN(port_in), .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE(pad_oe));

   task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
      samples_checked++;
      if (act !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
      end
   endtask

   // one bus cycle; held until waitrequest is seen low
   task automatic av(input logic is_wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= is_wr;
      rd <= !is_wr;
      do begin
         @(posedge clk);
         n++;
      end while (wait_rq !== 1'b0 && n < 20);
      if (n >= 20) check(1'b1, 1'b0, "waitrequest stuck");
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      av(1'b0, a, 32'h0, 4'h0);
      check(got, exp, what);
   endtask

   task automatic reset_state();
      rd_chk(CONV_CTRL_OFFS, 32'h0, "control after reset");
      rd_chk(LEVEL_CTRL_OFFS, 32'h0, "level after reset");
      @(negedge clk);
      check(outs, 8'h11, "outputs after reset");
      check(lvl_tap, 32'h0, "taps after reset");
   endtask

   task automatic end_test(input string name);
      $display("test %s done, %0d mismatches so far", name, error_cnt);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] c;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      reset_state();
      end_test("reset");
      av(1'b1, CONV_CTRL_OFFS, 32'hffff_ffff, 4'hf);
      rd_chk(CONV_CTRL_OFFS, 32'h0000_00ed, "control mask");
      check(outs, 8'he2, "code 11 drives no source");
      av(1'b1, LEVEL_CTRL_OFFS, 32'hffff_ffff, 4'hf);
      rd_chk(LEVEL_CTRL_OFFS, 32'h0000_001f, "level mask");
      av(1'b1, LEVEL_CTRL_OFFS, 32'h0, 4'he);
      rd_chk(LEVEL_CTRL_OFFS, 32'h0000_001f, "byte lane off");
      av(1'b1, 4'hc, 32'h0, 4'hf);
      rd_chk(4'hc, 32'h0, "unmapped read");
      rd_chk(CONV_CTRL_OFFS, 32'h0000_00ed, "unmapped write dropped");
      end_test("masks");
      av(1'b1, CONV_CTRL_OFFS, 32'h80, 4'hf);
      for (int i = 0; i < 32; i++) begin
         av(1'b1, LEVEL_CTRL_OFFS, i, 4'h1);
         @(negedge clk);
         check(lvl_sel, i, "level select");
         check(lvl_tap, 32'h1 << i, "level tap");
      end
      av(1'b1, CONV_CTRL_OFFS, 32'h0, 4'hf);
      @(negedge clk);
      check(lvl_tap, 32'h0, "taps off when disabled");
      end_test("levels");
      for (int k = 0; k < 8; k++) begin
         c = {k[2], k[2], 2'b00, k[1:0], 1'b0, k[0]};
         av(1'b1, CONV_CTRL_OFFS, {24'h0, c}, 4'h1);
         rd_chk(CONV_CTRL_OFFS, {24'h0, c}, "control readback");
         check(outs, {k[2], k[2], 1'b0, k[1:0] == 2'd0, k[1:0] == 2'd1, k[1:0] == 2'd2, k[0], !k[0]},
            "source decode");
      end
      end_test("sources");
      port_out <= 1'b1;
      port_oe <= 1'b1;
      pad_i <= 1'b1;
      av(1'b1, CONV_CTRL_OFFS, 32'h0, 4'hf);
      repeat (5) @(negedge clk);
      check(pins, 4'b1110, "digital pin path");
      av(1'b1, CONV_CTRL_OFFS, 32'h20, 4'hf);
      repeat (5) @(negedge clk);
      check(pins, 4'b0001, "pin in converter mode");
      av(1'b1, CONV_CTRL_OFFS, 32'h0, 4'hf);
      repeat (5) @(negedge clk);
      check(pins, 4'b1110, "pin released");
      end_test("pin");
      av(1'b1, LEVEL_CTRL_OFFS, 32'h15, 4'hf);
      av(1'b1, CONV_CTRL_OFFS, 32'hed, 4'hf);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      reset_state();
      end_test("second reset");
      tally_and_finish();
   end

   initial begin
      #40000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
